// ### hmr_pkg.sv
package hmr_pkg;

    // ****************************************************
    // Register byte offsets
    // ****************************************************
    localparam logic [7:0] OFS_FIFO_LEVEL = 8'h68;
    localparam logic [7:0] OFS_RX_CFG = 8'h6C;
    localparam logic [7:0] OFS_TX_CFG = 8'h70;
    localparam logic [7:0] OFS_RECEIVE_DATAPATH_CONTROL = 8'h78;
    localparam logic [7:0] OFS_RX_FIFO_INFO = 8'h7C;
    localparam logic [7:0] OFS_TX_FIFO_INFO = 8'h80;
    localparam logic [7:0] OFS_RX_DROPPED = 8'hA0;
    localparam logic [7:0] OFS_CSR_CMD = 8'hA4;
    localparam logic [7:0] OFS_CSR_DATA = 8'hA8;
    localparam logic [7:0] OFS_AUTO_FLOW_CONTROL_CONFIG = 8'hAC;
    localparam logic [7:0] OFS_RX_IDLE_TRANS = 8'hB0;
    localparam logic [7:0] OFS_RX_IDLE_TIME = 8'hB4;
    localparam logic [7:0] OFS_TX_IDLE_TRANS = 8'hB8;
    localparam logic [7:0] OFS_TX_IDLE_TIME = 8'hBC;

    // ****************************************************
    // Field positions and reset values
    // ****************************************************
    localparam int TDA_LSB = 24;
    localparam int TSL_LSB = 16;
    localparam int RSL_LSB = 0;
    localparam int EA_LSB = 30;
    localparam logic [7:0] TDA_RST = 8'h48;
    localparam logic [7:0] TSL_RST = 8'h00;
    localparam logic [7:0] RSL_RST = 8'h00;
    localparam logic [1:0] EA_RST = 2'h0;
    localparam logic [1:0] EA_4B = 2'h0;
    localparam logic [1:0] EA_16B = 2'h1;
    localparam logic [1:0] EA_32B = 2'h2;
    localparam int BLK_SHIFT = 6;
    localparam int CMD_BUSY_BIT = 31;
    localparam int CMD_READ_BIT = 30;
    localparam logic [7:0] CSR_ADDR_MAC_CTRL = 8'h01;
    localparam int MAC_CTRL_EEE_BIT = 25;
    localparam int MAC_CTRL_FULL_DUPLEX_FLAG_BIT = 20;
    localparam logic [31:0] MAC_CTRL_RST = 32'h0000_0000;
    localparam logic [3:0] MII_IDLE_CODE = 4'h1;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int unsigned CLK_FREQ_HZ = 125_000_000;
    localparam int unsigned LINK_STABLE_S = 1;
    localparam int unsigned LINK_STABLE_CYCLES = LINK_STABLE_S * CLK_FREQ_HZ;
    localparam int unsigned US_TICK_US = 1;
    localparam int unsigned US_TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * US_TICK_US;

endpackage

// ### hmr_idle_if.sv
`timescale 1ns/1ps
// Qualifiers for receive idle decoding and the counters it produces.
interface hmr_idle_if;
    logic eee_en;
    logic full_duplex_flag;
    logic speed_100;
    logic an_eee;
    logic link_up;
    logic lpi_active;
    logic [31:0] trans_cnt;
    logic [31:0] time_cnt;
    modport ctrl (output eee_en, full_duplex_flag, speed_100, an_eee, link_up,
                  input lpi_active, trans_cnt, time_cnt);
    modport det (input eee_en, full_duplex_flag, speed_100, an_eee, link_up,
                 output lpi_active, trans_cnt, time_cnt);
endinterface

// ### hmr_rx_idle.sv
`timescale 1ns/1ps
module hmr_rx_idle
    import hmr_pkg::*;
#(
    parameter int unsigned LINK_STABLE_CYC = LINK_STABLE_CYCLES
) (
    input wire logic clk_i, // Core clock.
    input wire logic rst_i, // Asynchronous reset, active high.
    input wire logic [5:0] mii_rx_i, // Data valid, error, nibble from the pins.
    hmr_idle_if.det idle // Qualifiers in, counters out.
);
    localparam int CW = $clog2(LINK_STABLE_CYC + 1);
    localparam int UW = $clog2(US_TICK_CYCLES + 1);

    logic [5:0] s1_q, s2_q, s3_q, mii_q;
    logic [CW-1:0] stable_q;
    logic [UW-1:0] us_q;
    logic lpi_q, tick, link_ok, decode_en, lpi_raw;
    logic [31:0] trans_q, time_q;

    if (LINK_STABLE_CYC < 1) begin : g_chk
        $error("LINK_STABLE_CYC must be at least one");
    end

    // Three stages; a pin value is taken once the last two stages agree.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            s3_q <= 6'h00;
            mii_q <= 6'h00;
        end else begin
            s1_q <= mii_rx_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            mii_q <= (mii_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
        end
    end

    // Link must stay up without a break before idle is believed.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stable_q <= '0;
        end else if (!idle.link_up) begin
            stable_q <= '0;
        end else if (!link_ok) begin
            stable_q <= stable_q + CW'(1);
        end
    end

    // The live link level is part of the gate, so a drop stops decoding in the same cycle, not one later.
    assign link_ok = idle.link_up && (stable_q == CW'(LINK_STABLE_CYC));
    assign decode_en = idle.eee_en && idle.full_duplex_flag && idle.speed_100 && idle.an_eee && link_ok;
    assign lpi_raw = decode_en && !mii_q[5] && mii_q[4] && (mii_q[3:0] == MII_IDLE_CODE);

    // Free running microsecond time base.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            us_q <= '0;
        end else if (tick) begin
            us_q <= '0;
        end else begin
            us_q <= us_q + UW'(1);
        end
    end

    assign tick = (us_q == UW'(US_TICK_CYCLES - 1));

    // Counters; software cannot write them, and clearing the EEE enable holds them at zero.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lpi_q <= 1'b0;
            trans_q <= 32'h0000_0000;
            time_q <= 32'h0000_0000;
        end else begin
            lpi_q <= lpi_raw;
            if (!idle.eee_en) begin
                trans_q <= 32'h0000_0000;
                time_q <= 32'h0000_0000;
            end else begin
                if (lpi_raw && !lpi_q) begin
                    trans_q <= trans_q + 32'h0000_0001;
                end
                if (lpi_q && tick) begin
                    time_q <= time_q + 32'h0000_0001;
                end
            end
        end
    end

    assign idle.lpi_active = lpi_q;
    assign idle.trans_cnt = trans_q;
    assign idle.time_cnt = time_q;

    a_idle_code: assert property (@(posedge clk_i) disable iff (rst_i)
        lpi_q |-> $past(mii_q) == {2'b01, MII_IDLE_CODE})
        else $error("idle flagged without the idle code");
endmodule

// ### hmr_host_mac_regs.sv
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
module hmr_host_mac_regs
    import hmr_pkg::*;
#(
    parameter int unsigned LINK_STABLE_CYC = LINK_STABLE_CYCLES,
    parameter int FREE_W = 16,
    parameter int LVL_W = 12
) (
    input wire logic CORE_CLK_I, // Core clock.
    input wire logic RST_I, // Asynchronous reset, active high.
    input wire logic [7:0] WB_ADR_I, // Byte address.
    input wire logic [31:0] WB_DAT_I, // Write data.
    output logic [31:0] WB_DAT_O, // Read data.
    input wire logic [3:0] WB_SEL_I, // Byte lanes.
    input wire logic WB_WE_I, // Write enable.
    input wire logic WB_STB_I, // Strobe.
    input wire logic WB_CYC_I, // Cycle.
    output logic WB_ACK_O, // Acknowledge.
    input wire logic MII_RXDV_I, // Receive data valid pin.
    input wire logic MII_RXER_I, // Receive error pin.
    input wire logic [3:0] MII_RXD_I, // Receive nibble pins.
    input wire logic PHY_LINK_UP_I, // Link status.
    input wire logic PHY_SPEED_100_I, // Link runs at 100 Mbps.
    input wire logic PHY_AN_EEE_100_I, // Both ends support EEE at 100 Mbps.
    input wire logic [FREE_W-1:0] TX_DATA_FREE_I, // Free data space in bytes.
    input wire logic [LVL_W-1:0] TX_STS_USED_I, // Used status words.
    input wire logic [LVL_W-1:0] RX_STS_USED_I, // Used status words.
    output logic TX_DATA_SPACE_IRQ_O, // Transmit space level flag.
    output logic TX_STATUS_LEVEL_IRQ_O, // Transmit status level flag.
    output logic RX_STATUS_LEVEL_IRQ_O, // Receive status level flag.
    input wire logic RX_RD_I, // Host reads one receive word.
    input wire logic [31:0] RX_FIFO_DATA_I, // Head word of the data FIFO.
    input wire logic RX_FIFO_LAST_I, // Head word ends the buffer.
    input wire logic RX_FIFO_VALID_I, // Head word present.
    output logic RX_FIFO_POP_O, // Advance the data FIFO.
    output logic [31:0] RX_RD_DATA_O, // Word returned to the host.
    output logic RX_RD_VALID_O, // Returned word valid.
    output logic RX_RD_PAD_O // Returned word is padding.
);

    if (FREE_W < BLK_SHIFT + 8 || LVL_W < 8) begin : g_chk
        $error("FREE_W or LVL_W too narrow for the thresholds");
    end

    // ****************************************************
    // Bus slave
    // ****************************************************
    logic ack_q;
    logic [31:0] dat_q, rd_d;
    logic [7:0] adr_w;
    logic req, wr_req, rd_req;
    logic [7:0] tda_q, tsl_q, rsl_q;
    logic [1:0] ea_q;
    logic cmd_busy_q, cmd_read_q;
    logic [7:0] cmd_addr_q;
    logic [31:0] csr_data_q, mac_ctrl_q, wr_cmd, wr_lvl;
    hmr_idle_if idle ();

    // Merge the enabled byte lanes of a write into an old word.
    function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign adr_w = {WB_ADR_I[7:2], 2'b00};
    assign req = WB_CYC_I && WB_STB_I && !ack_q;
    assign wr_req = req && WB_WE_I;
    assign rd_req = req && !WB_WE_I;

    // Read multiplexer; registers outside this block's scope read zero.
    always_comb begin
        rd_d = 32'h0000_0000;
        case (adr_w)
            OFS_FIFO_LEVEL: rd_d = {tda_q, tsl_q, 8'h00, rsl_q};
            OFS_RX_CFG: rd_d = {ea_q, 30'h0000_0000};
            OFS_CSR_CMD: rd_d = {cmd_busy_q, cmd_read_q, 22'h00_0000, cmd_addr_q};
            OFS_CSR_DATA: rd_d = csr_data_q;
            OFS_RX_IDLE_TRANS: rd_d = idle.trans_cnt;
            OFS_RX_IDLE_TIME: rd_d = idle.time_cnt;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // One wait-free ack per request, dropped in the next cycle.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (rd_req) begin
                dat_q <= rd_d;
            end
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;

    // ****************************************************
    // Configuration registers
    // ****************************************************
    assign wr_lvl = apply_sel({tda_q, tsl_q, 8'h00, rsl_q}, WB_DAT_I, WB_SEL_I);

    // Level thresholds; the reserved byte is not stored.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tda_q <= TDA_RST;
            tsl_q <= TSL_RST;
            rsl_q <= RSL_RST;
        end else if (wr_req && adr_w == OFS_FIFO_LEVEL) begin
            tda_q <= wr_lvl[TDA_LSB +: 8];
            tsl_q <= wr_lvl[TSL_LSB +: 8];
            rsl_q <= wr_lvl[RSL_LSB +: 8];
        end
    end

    // End alignment; only the top byte lane carries it.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ea_q <= EA_RST;
        end else if (wr_req && adr_w == OFS_RX_CFG && WB_SEL_I[3]) begin
            ea_q <= WB_DAT_I[EA_LSB +: 2];
        end
    end

    // ****************************************************
    // Indirect MAC CSR access
    // ****************************************************
    assign wr_cmd = apply_sel({cmd_busy_q, cmd_read_q, 22'h00_0000, cmd_addr_q}, WB_DAT_I, WB_SEL_I);

    // A command with busy set runs in the next cycle; writes while busy are dropped.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cmd_busy_q <= 1'b0;
            cmd_read_q <= 1'b0;
            cmd_addr_q <= 8'h00;
        end else if (cmd_busy_q) begin
            cmd_busy_q <= 1'b0;
        end else if (wr_req && adr_w == OFS_CSR_CMD) begin
            cmd_busy_q <= wr_cmd[CMD_BUSY_BIT];
            cmd_read_q <= wr_cmd[CMD_READ_BIT];
            cmd_addr_q <= wr_cmd[7:0];
        end
    end

    // The data register is loaded by software or by a CSR read.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            csr_data_q <= 32'h0000_0000;
        end else if (cmd_busy_q && cmd_read_q) begin
            csr_data_q <= (cmd_addr_q == CSR_ADDR_MAC_CTRL) ? mac_ctrl_q : 32'h0000_0000;
        end else if (!cmd_busy_q && wr_req && adr_w == OFS_CSR_DATA) begin
            csr_data_q <= apply_sel(csr_data_q, WB_DAT_I, WB_SEL_I);
        end
    end

    // MAC control is reachable only through the command register.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mac_ctrl_q <= MAC_CTRL_RST;
        end else if (cmd_busy_q && !cmd_read_q && cmd_addr_q == CSR_ADDR_MAC_CTRL) begin
            mac_ctrl_q <= csr_data_q;
        end
    end

    // ****************************************************
    // Receive idle detection
    // ****************************************************
    assign idle.eee_en = mac_ctrl_q[MAC_CTRL_EEE_BIT];
    assign idle.full_duplex_flag = mac_ctrl_q[MAC_CTRL_FULL_DUPLEX_FLAG_BIT];
    assign idle.speed_100 = PHY_SPEED_100_I;
    assign idle.an_eee = PHY_AN_EEE_100_I;
    assign idle.link_up = PHY_LINK_UP_I;

    hmr_rx_idle #(
        .LINK_STABLE_CYC(LINK_STABLE_CYC)
    ) u_rx_idle (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .mii_rx_i({MII_RXDV_I, MII_RXER_I, MII_RXD_I}),
        .idle(idle.det)
    );

    // ****************************************************
    // FIFO level flags
    // ****************************************************
    logic [FREE_W-BLK_SHIFT-1:0] free_blk;
    logic tda_hit, tsl_hit, rsl_hit;
    logic tda_irq_q, tsl_irq_q, rsl_irq_q;

    assign free_blk = TX_DATA_FREE_I[FREE_W-1:BLK_SHIFT];
    assign tda_hit = free_blk > {{(FREE_W-BLK_SHIFT-8){1'b0}}, tda_q};
    assign tsl_hit = TX_STS_USED_I > {{(LVL_W-8){1'b0}}, tsl_q};
    assign rsl_hit = RX_STS_USED_I > {{(LVL_W-8){1'b0}}, rsl_q};

    // Flags are levels; the interrupt status register latches them elsewhere.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tda_irq_q <= 1'b0;
            tsl_irq_q <= 1'b0;
            rsl_irq_q <= 1'b0;
        end else begin
            tda_irq_q <= tda_hit;
            tsl_irq_q <= tsl_hit;
            rsl_irq_q <= rsl_hit;
        end
    end

    assign TX_DATA_SPACE_IRQ_O = tda_irq_q;
    assign TX_STATUS_LEVEL_IRQ_O = tsl_irq_q;
    assign RX_STATUS_LEVEL_IRQ_O = rsl_irq_q;

    // ****************************************************
    // Receive end alignment padding
    // ****************************************************
    logic [2:0] pad_left_q, word_cnt_q;
    logic [1:0] pkt_ea_q, eff_ea;
    logic in_pkt_q, pop_q, rvalid_q, rpad_q;
    logic [31:0] rdata_q;
    logic take, last_take;

    // Words still needed to reach the alignment after n words; reserved acts as 4 bytes.
    function automatic logic [2:0] pad_words(input logic [1:0] ea, input logic [2:0] n);
        logic [2:0] mask;
        mask = (ea == EA_32B) ? 3'h7 : (ea == EA_16B) ? 3'h3 : 3'h0;
        return (3'h0 - n) & mask;
    endfunction

    // The alignment is caught at the first word so a change mid packet cannot tear it.
    assign eff_ea = in_pkt_q ? pkt_ea_q : ea_q;
    assign take = RX_RD_I && pad_left_q == 3'h0 && RX_FIFO_VALID_I && !pop_q;
    assign last_take = take && RX_FIFO_LAST_I;

    // A FIFO word read in the same cycle as a pop is dropped because the FIFO head is still moving.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pad_left_q <= 3'h0;
            word_cnt_q <= 3'h0;
            pkt_ea_q <= EA_RST;
            in_pkt_q <= 1'b0;
            pop_q <= 1'b0;
            rvalid_q <= 1'b0;
            rpad_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            pop_q <= take;
            rvalid_q <= 1'b0;
            rpad_q <= 1'b0;
            if (RX_RD_I && pad_left_q != 3'h0) begin
                pad_left_q <= pad_left_q - 3'h1;
                rdata_q <= 32'h0000_0000;
                rvalid_q <= 1'b1;
                rpad_q <= 1'b1;
            end else if (take) begin
                rdata_q <= RX_FIFO_DATA_I;
                rvalid_q <= 1'b1;
                if (!in_pkt_q) begin
                    pkt_ea_q <= ea_q;
                end
                if (RX_FIFO_LAST_I) begin
                    pad_left_q <= pad_words(eff_ea, word_cnt_q + 3'h1);
                    word_cnt_q <= 3'h0;
                    in_pkt_q <= 1'b0;
                end else begin
                    word_cnt_q <= word_cnt_q + 3'h1;
                    in_pkt_q <= 1'b1;
                end
            end
        end
    end

    assign RX_FIFO_POP_O = pop_q;
    assign RX_RD_DATA_O = rdata_q;
    assign RX_RD_VALID_O = rvalid_q;
    assign RX_RD_PAD_O = rpad_q;

    // ****************************************************
    // Assertions
    // ****************************************************
    logic boot_q;

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            boot_q <= 1'b0;
        end else begin
            boot_q <= 1'b1;
        end
    end

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);

    a_decode_gate: assert property (idle.lpi_active |->
        $past(idle.eee_en && idle.full_duplex_flag && idle.speed_100 && idle.an_eee && idle.link_up))
        else $error("idle decoded without all qualifiers");
    a_link_settle: assert property ($rose(PHY_LINK_UP_I) |-> !idle.lpi_active [*8])
        else $error("idle decoded right after link up");
    a_trans_step: assert property ($rose(idle.lpi_active) && $past(idle.eee_en) |->
        idle.trans_cnt == $past(idle.trans_cnt) + 32'h0000_0001)
        else $error("idle rise not counted");
    a_time_still: assert property ($past(!idle.lpi_active && idle.eee_en) |->
        $stable(idle.time_cnt))
        else $error("duration counted outside idle");
    a_cnt_keep: assert property ($past(idle.eee_en) |->
        idle.trans_cnt >= $past(idle.trans_cnt) && idle.time_cnt >= $past(idle.time_cnt))
        else $error("idle counter went down");
    a_cnt_zero: assert property ($past(!idle.eee_en) |->
        idle.trans_cnt == 32'h0000_0000 && idle.time_cnt == 32'h0000_0000)
        else $error("idle counter not held at zero");
    a_csr_done: assert property ($rose(cmd_busy_q) |=> !cmd_busy_q)
        else $error("indirect command did not finish");
    a_tda_flag: assert property (tda_hit |=> TX_DATA_SPACE_IRQ_O)
        else $error("space flag missing");
    a_tsl_flag: assert property (TX_STATUS_LEVEL_IRQ_O |-> $past(tsl_hit))
        else $error("transmit status flag without cause");
    a_rsl_flag: assert property (rsl_hit ##1 rsl_hit |=> RX_STATUS_LEVEL_IRQ_O)
        else $error("receive status flag missing");
    a_reset_thr: assert property (!boot_q |->
        tda_q == TDA_RST && tsl_q == TSL_RST && rsl_q == RSL_RST)
        else $error("threshold reset values wrong");
    a_pad_align: assert property (last_take && eff_ea == EA_32B |=>
        (($past(word_cnt_q) + 3'h1 + pad_left_q) & 3'h7) == 3'h0)
        else $error("padding misses the alignment");
    a_pad_none: assert property (last_take && eff_ea == EA_4B |=> pad_left_q == 3'h0)
        else $error("padding added at 4-byte alignment");
    a_rsvd_zero: assert property (rd_req && adr_w == OFS_FIFO_LEVEL |=>
        WB_ACK_O && WB_DAT_O[15:8] == 8'h00)
        else $error("reserved bits read nonzero");
    a_ack_drop: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    c_idle_entry: cover property ($rose(idle.lpi_active));
    c_pad_32: cover property (last_take && eff_ea == EA_32B ##1 pad_left_q != 3'h0);
    c_csr_read: cover property (cmd_busy_q && cmd_read_q);
    c_tda_rise: cover property ($rose(TX_DATA_SPACE_IRQ_O));
endmodule

// ### hmr_phy_model.sv
`timescale 1ns/1ps
// ****************************************************
// Receive side of the PHY
// ****************************************************
module hmr_phy_model
    import hmr_pkg::*;
(
    input wire logic clk_i, // Core clock.
    input wire logic idle_i, // Ask for low-power idle signalling.
    output logic rxdv_o, // Data valid pin.
    output logic rxer_o, // Error pin.
    output logic [3:0] rxd_o // Nibble pins.
);
    // Pins start quiet so the decoder never sees an unknown at time zero.
    initial {rxdv_o, rxer_o, rxd_o} = 6'h00;
    // Outside idle the nibble toggles, so a decoder that latches a stale code is caught.
    always @(posedge clk_i) begin
        rxdv_o <= 1'b0;
        rxer_o <= idle_i;
        rxd_o <= idle_i ? MII_IDLE_CODE : ~rxd_o;
    end
endmodule

// ### test_host_mac_eee_rx_fifo_regs.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t mismatch got %h", $time, a); end end
// ****************************************************
// Register, level flag, idle counter and padding bench
// ****************************************************
module test_host_mac_eee_rx_fifo_regs;
    import hmr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, lnk = 1'b0, idle = 1'b0, rd = 1'b0, fv = 1'b0, got;
    logic spd = 1'b1;
    logic ack, dv, er, pop, rv, pad, f1, f2, f3;
    logic [3:0] rxd;
    logic [7:0] adr = 8'h00;
    logic [11:0] tsu = 12'h000, rsu = 12'h000;
    logic [15:0] free = 16'h0000;
    logic [31:0] wd = 32'h0, rdo, rdd, q;
    int num_errors = 0, checks = 0, pads[3] = '{0, 3, 7};
    // Free-running core clock, 8 ns period.
    always #4 clk = ~clk;
    hmr_host_mac_regs #(.LINK_STABLE_CYC(20)) dut_u (.CORE_CLK_I(clk), .RST_I(rst), .WB_ADR_I(adr),
        .WB_DAT_I(wd), .WB_DAT_O(rdo), .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_STB_I(cyc), .WB_CYC_I(cyc),
        .WB_ACK_O(ack), .MII_RXDV_I(dv), .MII_RXER_I(er), .MII_RXD_I(rxd), .PHY_LINK_UP_I(lnk),
        .PHY_SPEED_100_I(spd), .PHY_AN_EEE_100_I(1'b1), .TX_DATA_FREE_I(free), .TX_STS_USED_I(tsu),
        .RX_STS_USED_I(rsu), .TX_DATA_SPACE_IRQ_O(f1), .TX_STATUS_LEVEL_IRQ_O(f2), .RX_STATUS_LEVEL_IRQ_O(f3),
        .RX_RD_I(rd), .RX_FIFO_DATA_I(32'hA5A5_0001), .RX_FIFO_LAST_I(1'b1), .RX_FIFO_VALID_I(fv),
        .RX_FIFO_POP_O(pop), .RX_RD_DATA_O(rdd), .RX_RD_VALID_O(rv), .RX_RD_PAD_O(pad));
    hmr_phy_model phy_u (.clk_i(clk), .idle_i(idle), .rxdv_o(dv), .rxer_o(er), .rxd_o(rxd));
    // One classic cycle; the request stands until ack is sampled high, read data taken at that edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdo;
        cyc <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            complete_run();
        end
    endtask
    // One receive read pulse; a refused read simply returns with got low.
    task automatic rx();
        int n;
        n = 0;
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (rv !== 1'b1 && n < 4);
        got = (rv === 1'b1);
    endtask
    // Single place where the run ends.
    task automatic complete_run();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence of tests.
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        lnk <= 1'b1;
        wb(1'b0, OFS_FIFO_LEVEL, 32'h0);
        `CHK(q, {TDA_RST, TSL_RST, 8'h00, RSL_RST})
        wb(1'b1, OFS_FIFO_LEVEL, 32'hFFFF_FFFF);
        wb(1'b0, OFS_FIFO_LEVEL, 32'h0);
        `CHK(q, 32'hFFFF_00FF)
        wb(1'b0, OFS_TX_CFG, 32'h0);
        `CHK(q, 32'h0)
        wb(1'b1, OFS_FIFO_LEVEL, 32'h0205_0007);
        free <= 16'h00C0;
        tsu <= 12'h005;
        rsu <= 12'h008;
        repeat (3) @(posedge clk);
        `CHK({f1, f2, f3}, 3'b101)
        free <= 16'h0080;
        tsu <= 12'h006;
        rsu <= 12'h007;
        repeat (3) @(posedge clk);
        `CHK({f1, f2, f3}, 3'b010)
        $display("register and level tests done");
        idle <= 1'b1;
        repeat (300) @(posedge clk);
        idle <= 1'b0;
        wb(1'b0, OFS_RX_IDLE_TRANS, 32'h0);
        `CHK(q, 32'h0)
        wb(1'b1, OFS_CSR_DATA, 32'h0210_0000);
        wb(1'b1, OFS_CSR_CMD, {24'h800000, CSR_ADDR_MAC_CTRL});
        wb(1'b1, OFS_CSR_DATA, 32'h0);
        wb(1'b1, OFS_CSR_CMD, {24'hC00000, CSR_ADDR_MAC_CTRL});
        wb(1'b0, OFS_CSR_DATA, 32'h0);
        `CHK(q, 32'h0210_0000)
        idle <= 1'b1;
        repeat (400) @(posedge clk);
        idle <= 1'b0;
        repeat (20) @(posedge clk);
        wb(1'b1, OFS_RX_IDLE_TRANS, 32'h55);
        wb(1'b0, OFS_RX_IDLE_TRANS, 32'h0);
        `CHK(q, 32'h1)
        wb(1'b0, OFS_RX_IDLE_TRANS, 32'h0);
        `CHK(q, 32'h1)
        wb(1'b0, OFS_RX_IDLE_TIME, 32'h0);
        `CHK(q >= 32'h2 && q <= 32'h4, 1'b1)
        // Idle at the wrong speed must not be decoded.
        spd <= 1'b0;
        idle <= 1'b1;
        repeat (50) @(posedge clk);
        idle <= 1'b0;
        repeat (20) @(posedge clk);
        wb(1'b0, OFS_RX_IDLE_TRANS, 32'h0);
        `CHK(q, 32'h1)
        // A one-cycle link drop restarts the settle time; idle is ignored until it has run out.
        spd <= 1'b1;
        lnk <= 1'b0;
        idle <= 1'b1;
        @(posedge clk);
        lnk <= 1'b1;
        repeat (8) @(posedge clk);
        wb(1'b0, OFS_RX_IDLE_TRANS, 32'h0);
        `CHK(q, 32'h1)
        repeat (30) @(posedge clk);
        wb(1'b0, OFS_RX_IDLE_TRANS, 32'h0);
        `CHK(q, 32'h2)
        idle <= 1'b0;
        $display("idle counter tests done");
        foreach (pads[k]) begin
            wb(1'b1, OFS_RX_CFG, {2'(k), 30'h0});
            fv <= 1'b1;
            rx();
            fv <= 1'b0;
            `CHK({got, pop, pad, rdd}, {3'b110, 32'hA5A5_0001})
            for (int i = 0; i <= pads[k]; i++) begin
                rx();
                `CHK(got, 1'(i < pads[k]))
                if (i < pads[k]) `CHK({pop, pad, rdd}, {2'b01, 32'h0})
            end
        end
        $display("padding tests done");
        complete_run();
    end
endmodule
